/* File: design/status_pkg.sv */
// Package with the status model layout, command codes and carrier structs.
package status_pkg;

  // ----------------------------------------
  // Register bit positions
  // ----------------------------------------
  localparam int ESR_OPC_BIT = 0;
  localparam int ESR_QUERY_ERR_BIT = 2;
  localparam int ESR_DEV_ERR_BIT = 3;
  localparam int ESR_EXEC_ERR_BIT = 4;
  localparam int ESR_CMD_ERR_BIT = 5;
  localparam int ESR_POWER_ON_BIT = 7;
  localparam int OPER_CAL_BIT = 0;
  localparam int OPER_RANGE_BIT = 2;
  localparam int OPER_MEAS_BIT = 4;
  localparam int OPER_WAIT_TRIG_BIT = 5;
  localparam int QUES_FREQ_BIT = 5;
  localparam int QUES_AMPL_BIT = 9;
  localparam int STB_EAV_BIT = 2;
  localparam int STB_QSB_BIT = 3;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_RQS_BIT = 6;
  localparam int STB_OSB_BIT = 7;

  // ----------------------------------------
  // Widths, masks and reset values
  // ----------------------------------------
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam logic [15:0] WORD_LEGAL_MASK = 16'h7FFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] ASCII_ONE = 8'h31;
  localparam logic [7:0] ASCII_ZERO = 8'h30;

  // ----------------------------------------
  // Commands from the parser and codes from the USB488 control side
  // ----------------------------------------
  typedef enum logic [4:0] {
    CMD_NONE, CMD_CLS, CMD_ESE, CMD_ESE_Q, CMD_ESR_Q, CMD_OPC, CMD_OPC_Q,
    CMD_RST, CMD_SRE, CMD_SRE_Q, CMD_STB_Q, CMD_TST_Q, CMD_WAI,
    CMD_OPER_EVT_Q, CMD_OPER_COND_Q, CMD_OPER_ENA, CMD_OPER_ENA_Q,
    CMD_QUES_EVT_Q, CMD_QUES_COND_Q, CMD_QUES_ENA, CMD_QUES_ENA_Q
  } cmd_t;

  typedef enum logic [2:0] {
    CTL_NONE, CTL_INIT_CLEAR, CTL_READ_STB, CTL_REN, CTL_GTL, CTL_LLO
  } ctl_t;

  // Request from the command parser.
  typedef struct packed {
    logic valid;
    cmd_t cmd;
    logic [15:0] data;
  } cmd_req_t;

  // Instrument conditions presented by the measurement side.
  typedef struct packed {
    logic calibrating;
    logic ranging;
    logic measuring;
    logic wait_trig;
    logic overrun;
    logic over_range;
  } inst_cond_t;

  // Error pulses from command execution.
  typedef struct packed {
    logic query_err;
    logic dev_err;
    logic exec_err;
    logic cmd_err;
  } err_evt_t;

  // Reply to the host.
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } reply_t;

endpackage

/* File: design/event_group.sv */
// One condition, event and enable register group with its summary bit.
module event_group
  import status_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Condition and control
  input wire logic [WIDTH-1:0] cond,
  input wire logic [WIDTH-1:0] legal_mask,
  input wire logic [WIDTH-1:0] set_evt,
  input wire logic clear_evt,
  input wire logic ena_wr,
  input wire logic [WIDTH-1:0] ena_data,
  // State out
  output logic [WIDTH-1:0] cond_out,
  output logic [WIDTH-1:0] event_out,
  output logic [WIDTH-1:0] enable_out,
  output logic summary
);
  import status_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] evt;
    logic [WIDTH-1:0] ena;
  } grp_state_t;

  grp_state_t state_reg;
  grp_state_t state_next;
  logic [WIDTH-1:0] cond_legal;
  logic [WIDTH-1:0] rise;

  assign cond_legal = cond & legal_mask; // [R24]
  assign rise = cond_legal & ~state_reg.prev; // [R7]

  always_comb begin
    state_next = state_reg;
    state_next.prev = cond_legal;
    // A rise in the clearing cycle survives, so no event is lost.
    if (clear_evt) begin
      state_next.evt = '0; // [R8]
    end
    state_next.evt = (state_next.evt | rise | set_evt) & legal_mask; // [R7]
    if (ena_wr) begin
      state_next.ena = ena_data & legal_mask; // [R9]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cond_out = cond_legal; // [R6]
  assign event_out = state_reg.evt;
  assign enable_out = state_reg.ena;
  assign summary = |(state_reg.evt & state_reg.ena); // [R25]

endmodule

/* File: design/status_reporting.sv */
// Status reporting core: event groups, status byte and common commands.
// Operation
// R1 - Power-up sets standard event bit 7.
// R2 - Errors set standard event bits 2 to 5.
// R3 - Operation condition bits 0,2,4,5 reflect activity.
// R4 - Overrun sets questionable bit 5.
// R5 - Over-range sets questionable bit 9.
// R6 - Condition registers read-only, follow state live.
// R7 - Event bits latch on rising condition only.
// R8 - Reading an event register clears it.
// R9 - Enable mask selects bits into summary.
// R10 - Status enable selects bits raising request.
// R11 - Initiate clear empties input and output buffers.
// R12 - Remote and local controls change nothing.
// R13 - Clear status clears events, queues, not masks.
// R14 - Event status query reads, clears; enable programmable.
// R15 - Operation complete bit set after pending commands.
// R16 - Completion query answers ASCII one when idle.
// R17 - Reset restores power-on configuration.
// R18 - Self-test query returns zero or one.
// R19 - Wait holds later commands until earlier finish.
// R20 - Status byte query returns current status byte.
// R21 - Service request signalled through interrupt path.
// R22 - Host puts no query after identification query.
// R23 - Status byte bit layout EAV,QSB,MAV,ESB,RQS,OSB.
// R24 - Bit 15 of word registers reads zero.
// R25 - Summary is OR of event AND enable.
module status_reporting
  import status_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Command parser side
  input wire status_pkg::cmd_req_t cmd_req,
  output logic cmd_ready,
  output status_pkg::reply_t reply,
  // USB488 control side
  input wire status_pkg::ctl_t ctl_code,
  input wire logic ctl_valid,
  output logic [7:0] ctl_stb,
  output logic srq_intr,
  // Instrument side
  input wire status_pkg::inst_cond_t inst_cond,
  input wire status_pkg::err_evt_t err_evt,
  input wire logic exec_busy,
  input wire logic selftest_fail,
  input wire logic error_queue_nonempty,
  input wire logic output_pending,
  output logic clear_buffers,
  output logic clear_error_queue,
  output logic config_reset
);
  import status_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE, ST_OPC_WAIT, ST_OPCQ_WAIT, ST_WAI_WAIT
  } seq_t;

  typedef struct packed {
    seq_t seq;
    logic [7:0] esr;
    logic [7:0] ese;
    logic [7:0] sre;
    logic power_on;
    logic srq_prev;
    logic srq;
    reply_t reply;
    logic clr_buf;
    logic clr_err;
    logic cfg_rst;
    logic [7:0] ctl_stb;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;

  // ----------------------------------------
  // Register groups
  // ----------------------------------------
  logic [WORD_W-1:0] oper_cond;
  logic [WORD_W-1:0] ques_cond;
  logic [WORD_W-1:0] oper_cond_out;
  logic [WORD_W-1:0] oper_evt;
  logic [WORD_W-1:0] oper_ena;
  logic [WORD_W-1:0] ques_cond_out;
  logic [WORD_W-1:0] ques_evt;
  logic [WORD_W-1:0] ques_ena;
  logic oper_sum;
  logic ques_sum;
  logic oper_clr;
  logic ques_clr;
  logic oper_ena_wr;
  logic ques_ena_wr;
  logic cmd_take;
  logic cls_take;
  logic rst_take;

  always_comb begin
    oper_cond = WORD_ZERO;
    oper_cond[OPER_CAL_BIT] = inst_cond.calibrating; // [R3]
    oper_cond[OPER_RANGE_BIT] = inst_cond.ranging; // [R3]
    oper_cond[OPER_MEAS_BIT] = inst_cond.measuring; // [R3]
    oper_cond[OPER_WAIT_TRIG_BIT] = inst_cond.wait_trig; // [R3]
    ques_cond = WORD_ZERO;
    ques_cond[QUES_FREQ_BIT] = inst_cond.overrun; // [R4]
    ques_cond[QUES_AMPL_BIT] = inst_cond.over_range; // [R5]
  end

  // Commands are only taken in idle, which is how wait holds off later ones.
  assign cmd_ready = (state_reg.seq == ST_IDLE); // [R19]
  assign cmd_take = cmd_req.valid && cmd_ready;
  assign cls_take = cmd_take && (cmd_req.cmd == CMD_CLS);
  assign rst_take = cmd_take && (cmd_req.cmd == CMD_RST);
  assign oper_clr = cls_take || (cmd_take && cmd_req.cmd == CMD_OPER_EVT_Q); // [R8] [R13]
  assign ques_clr = cls_take || (cmd_take && cmd_req.cmd == CMD_QUES_EVT_Q); // [R8] [R13]
  assign oper_ena_wr = cmd_take && (cmd_req.cmd == CMD_OPER_ENA);
  assign ques_ena_wr = cmd_take && (cmd_req.cmd == CMD_QUES_ENA);

  event_group #(.WIDTH(WORD_W)) oper_group (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .cond(oper_cond),
    .legal_mask(WORD_LEGAL_MASK),
    .set_evt(WORD_ZERO),
    .clear_evt(oper_clr),
    .ena_wr(oper_ena_wr),
    .ena_data(cmd_req.data),
    .cond_out(oper_cond_out),
    .event_out(oper_evt),
    .enable_out(oper_ena),
    .summary(oper_sum)
  );

  event_group #(.WIDTH(WORD_W)) ques_group (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .cond(ques_cond),
    .legal_mask(WORD_LEGAL_MASK),
    .set_evt(WORD_ZERO),
    .clear_evt(ques_clr),
    .ena_wr(ques_ena_wr),
    .ena_data(cmd_req.data),
    .cond_out(ques_cond_out),
    .event_out(ques_evt),
    .enable_out(ques_ena),
    .summary(ques_sum)
  );

  // ----------------------------------------
  // Status byte
  // ----------------------------------------
  logic esb;
  logic [7:0] stb_base;
  logic rqs;
  logic [7:0] stb;

  assign esb = |(state_reg.esr & state_reg.ese); // [R25]

  always_comb begin
    stb_base = BYTE_ZERO;
    stb_base[STB_EAV_BIT] = error_queue_nonempty; // [R23]
    stb_base[STB_QSB_BIT] = ques_sum; // [R23]
    stb_base[STB_MAV_BIT] = output_pending; // [R23]
    stb_base[STB_ESB_BIT] = esb; // [R23]
    stb_base[STB_OSB_BIT] = oper_sum; // [R23]
    // The request bit itself is never a source, avoiding a loop.
    rqs = |(stb_base & state_reg.sre); // [R10]
    stb = stb_base;
    stb[STB_RQS_BIT] = rqs; // [R23]
  end

  // ----------------------------------------
  // Command and control sequencing
  // ----------------------------------------
  logic [7:0] err_bits;

  always_comb begin
    err_bits = BYTE_ZERO;
    err_bits[ESR_QUERY_ERR_BIT] = err_evt.query_err; // [R2]
    err_bits[ESR_DEV_ERR_BIT] = err_evt.dev_err; // [R2]
    err_bits[ESR_EXEC_ERR_BIT] = err_evt.exec_err; // [R2]
    err_bits[ESR_CMD_ERR_BIT] = err_evt.cmd_err; // [R2]
  end

  // ----------------------------------------
  // Standard event sources
  // ----------------------------------------
  logic [7:0] esr_set;

  // Hardware sources are merged after any read-clear, so a set that meets
  // a clear in the same cycle is kept, the power-on mark included.
  always_comb begin
    esr_set = err_bits; // [R2]
    esr_set[ESR_POWER_ON_BIT] = state_reg.power_on; // [R1]
  end

  // ----------------------------------------
  // Completion of earlier commands
  // ----------------------------------------
  logic exec_done;

  // Completion is taken from the executor's busy level alone, so a command
  // that never reports busy completes in the cycle after it is taken.
  assign exec_done = !exec_busy; // [R15] [R16] [R19]

  always_comb begin
    state_next = state_reg;
    state_next.reply = '0;
    state_next.clr_buf = 1'b0;
    state_next.clr_err = 1'b0;
    state_next.cfg_rst = 1'b0;
    state_next.srq = 1'b0;
    state_next.power_on = 1'b0;
    if (cmd_take) begin
      case (cmd_req.cmd)
        CMD_CLS: begin
          state_next.esr = BYTE_ZERO; // [R13]
          state_next.clr_err = 1'b1; // [R13]
        end
        CMD_ESE: begin
          state_next.ese = cmd_req.data[BYTE_W-1:0]; // [R14]
        end
        CMD_ESE_Q: begin
          state_next.reply = '{1'b1, {BYTE_ZERO, state_reg.ese}}; // [R14]
        end
        CMD_ESR_Q: begin
          state_next.reply = '{1'b1, {BYTE_ZERO, state_reg.esr}}; // [R14]
          state_next.esr = BYTE_ZERO; // [R8]
        end
        CMD_OPC: begin
          state_next.seq = ST_OPC_WAIT; // [R15]
        end
        CMD_OPC_Q: begin
          state_next.seq = ST_OPCQ_WAIT; // [R16]
        end
        CMD_RST: begin
          state_next.cfg_rst = 1'b1; // [R17]
        end
        CMD_SRE: begin
          state_next.sre = cmd_req.data[BYTE_W-1:0];
        end
        CMD_SRE_Q: begin
          state_next.reply = '{1'b1, {BYTE_ZERO, state_reg.sre}};
        end
        CMD_STB_Q: begin
          state_next.reply = '{1'b1, {BYTE_ZERO, stb}}; // [R20]
        end
        CMD_TST_Q: begin
          state_next.reply = '{1'b1, {BYTE_ZERO,
            (selftest_fail ? ASCII_ONE : ASCII_ZERO)}}; // [R18]
        end
        CMD_WAI: begin
          state_next.seq = ST_WAI_WAIT; // [R19]
        end
        CMD_OPER_EVT_Q: begin
          state_next.reply = '{1'b1, oper_evt}; // [R8]
        end
        CMD_OPER_COND_Q: begin
          state_next.reply = '{1'b1, oper_cond_out}; // [R6]
        end
        CMD_OPER_ENA_Q: begin
          state_next.reply = '{1'b1, oper_ena};
        end
        CMD_QUES_EVT_Q: begin
          state_next.reply = '{1'b1, ques_evt}; // [R8]
        end
        CMD_QUES_COND_Q: begin
          state_next.reply = '{1'b1, ques_cond_out}; // [R6]
        end
        CMD_QUES_ENA_Q: begin
          state_next.reply = '{1'b1, ques_ena};
        end
        default: begin
        end
      endcase
    end
    case (state_reg.seq)
      ST_OPC_WAIT: begin
        if (exec_done) begin
          state_next.esr[ESR_OPC_BIT] = 1'b1; // [R15]
          state_next.seq = ST_IDLE;
        end
      end
      ST_OPCQ_WAIT: begin
        if (exec_done) begin
          state_next.reply = '{1'b1, {BYTE_ZERO, ASCII_ONE}}; // [R16]
          state_next.seq = ST_IDLE;
        end
      end
      ST_WAI_WAIT: begin
        if (exec_done) begin
          state_next.seq = ST_IDLE; // [R19]
        end
      end
      default: begin
      end
    endcase
    // Sources are set last so a clear in the same cycle cannot drop them.
    state_next.esr = state_next.esr | esr_set; // [R1] [R2]
    if (rst_take) begin
      state_next.ese = BYTE_ZERO; // [R17]
      state_next.sre = BYTE_ZERO; // [R17]
    end
    if (ctl_valid) begin
      case (ctl_code)
        CTL_INIT_CLEAR: begin
          state_next.clr_buf = 1'b1; // [R11]
        end
        CTL_READ_STB: begin
          state_next.ctl_stb = stb;
        end
        CTL_REN, CTL_GTL, CTL_LLO: begin
          // Accepted only; there are no local controls to lock.
          state_next.ctl_stb = state_reg.ctl_stb; // [R12]
        end
        default: begin
        end
      endcase
    end
    // One interrupt pulse per rising request keeps the host from flooding.
    state_next.srq_prev = rqs;
    state_next.srq = rqs && !state_reg.srq_prev; // [R21]
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg <= '0;
      state_reg.power_on <= 1'b1; // [R1]
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reply = state_reg.reply;
  assign ctl_stb = state_reg.ctl_stb;
  assign srq_intr = state_reg.srq; // [R21]
  assign clear_buffers = state_reg.clr_buf; // [R11]
  assign clear_error_queue = state_reg.clr_err; // [R13]
  assign config_reset = state_reg.cfg_rst; // [R17]

endmodule

/* File: bench/host_bfm.sv */
// Host side model that issues commands and collects replies.
module host_bfm
  import status_pkg::*;
(
  input wire logic core_clk,
  input wire logic cmd_ready,
  input wire status_pkg::reply_t reply,
  output status_pkg::cmd_req_t cmd_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] last;
  int rcnt = 0;
  initial cmd_req = '0;
  // Ready is looked at mid-cycle, so the take edge is known without a race.
  // Only status commands are sent, so no query follows an identification query.
  task automatic send(input cmd_t c, input logic [15:0] d, output logic ok);
    int n;
    n = 0;
    @(posedge core_clk);
    cmd_req <= '{1'b1, c, d};
    do begin
      @(negedge core_clk);
      ok = (cmd_ready === 1'b1);
      @(posedge core_clk);
      n++;
    end while (!ok && n < 40);
    cmd_req <= '{1'b0, c, ~d};
  endtask
  always @(posedge core_clk) begin
    if (reply.valid === 1'b1) begin
      last <= reply.data;
      rcnt <= rcnt + 1;
    end
  end
endmodule

/* File: bench/status_reporting_chk.sv */
// Port checks for the status reporting core.
module status_reporting_chk
  import status_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire status_pkg::cmd_req_t cmd_req,
  input wire logic cmd_ready,
  input wire status_pkg::reply_t reply,
  input wire status_pkg::ctl_t ctl_code,
  input wire logic ctl_valid,
  input wire logic [7:0] ctl_stb,
  input wire logic srq_intr,
  input wire logic exec_busy,
  input wire logic selftest_fail,
  input wire logic error_queue_nonempty,
  input wire logic output_pending,
  input wire logic clear_buffers,
  input wire logic clear_error_queue,
  input wire logic config_reset
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic take;
  assign take = cmd_req.valid && cmd_ready;
  property p_clr;
    ctl_valid && ctl_code == CTL_INIT_CLEAR |=> clear_buffers;
  endproperty
  a_clr: assert property (p_clr) else $error("no buffer clear");
  property p_clr_src;
    clear_buffers |-> $past(ctl_valid && ctl_code == CTL_INIT_CLEAR);
  endproperty
  a_clr_src: assert property (p_clr_src) else $error("stray buffer clear");
  property p_local;
    ctl_valid && ctl_code inside {CTL_REN, CTL_GTL, CTL_LLO} |=> !clear_buffers && !config_reset;
  endproperty
  a_local: assert property (p_local) else $error("local control acted");
  property p_cls;
    take && cmd_req.cmd == CMD_CLS |=> clear_error_queue;
  endproperty
  a_cls: assert property (p_cls) else $error("no error queue clear");
  property p_esr;
    take && cmd_req.cmd == CMD_ESR_Q |=> reply.valid;
  endproperty
  a_esr: assert property (p_esr) else $error("no event reply");
  property p_rst;
    take && cmd_req.cmd == CMD_RST |=> config_reset;
  endproperty
  a_rst: assert property (p_rst) else $error("no config reset");
  property p_tst;
    take && cmd_req.cmd == CMD_TST_Q |=> reply.valid &&
      reply.data == {8'h00, $past(selftest_fail) ? ASCII_ONE : ASCII_ZERO};
  endproperty
  a_tst: assert property (p_tst) else $error("bad self-test reply");
  property p_hold;
    take && exec_busy && cmd_req.cmd inside {CMD_WAI, CMD_OPC} |=>
      !cmd_ready ##1 (!cmd_ready || !$past(exec_busy));
  endproperty
  a_hold: assert property (p_hold) else $error("wait not held");
  property p_stb;
    ctl_valid && ctl_code == CTL_READ_STB |=> ctl_stb[STB_MAV_BIT] == $past(output_pending)
      && ctl_stb[STB_EAV_BIT] == $past(error_queue_nonempty);
  endproperty
  a_stb: assert property (p_stb) else $error("bad status byte");
  property p_stb_keep;
    !$past(ctl_valid && ctl_code == CTL_READ_STB) |-> $stable(ctl_stb);
  endproperty
  a_stb_keep: assert property (p_stb_keep) else $error("status byte moved");
  property p_b15;
    reply.valid |-> !reply.data[15];
  endproperty
  a_b15: assert property (p_b15) else $error("bit 15 set");
  property p_srq;
    srq_intr |=> !srq_intr;
  endproperty
  a_srq: assert property (p_srq) else $error("long service pulse");
endmodule

/* File: bench/status_reporting_tb.sv */
// Self-checking bench for the status reporting core.
module status_reporting_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import status_pkg::*;
  logic core_clk, rst_b, cmd_ready, ctl_valid, srq_intr, exec_busy, selftest_fail;
  logic error_queue_nonempty, output_pending, clear_buffers, clear_error_queue, config_reset;
  logic [7:0] ctl_stb;
  cmd_req_t cmd_req;
  reply_t reply;
  ctl_t ctl_code;
  inst_cond_t inst_cond;
  err_evt_t err_evt;
  logic [15:0] esr, oper_ev, ques_ev, ese, sre, oper_ena, ques_ena;
  int mismatches, checked, srq_n, clr_n;
  status_reporting dut_u (.*);
  host_bfm host_u (.*);
  always @(posedge core_clk) begin
    srq_n <= srq_n + (srq_intr === 1'b1);
    clr_n <= clr_n + (clear_buffers === 1'b1);
  end
  // ----------------------------------------
  // Model and tasks
  // ----------------------------------------
  function automatic logic [15:0] oper_of(input inst_cond_t c);
    oper_of = '0;
    oper_of[OPER_CAL_BIT] = c.calibrating;
    oper_of[OPER_RANGE_BIT] = c.ranging;
    oper_of[OPER_MEAS_BIT] = c.measuring;
    oper_of[OPER_WAIT_TRIG_BIT] = c.wait_trig;
  endfunction
  function automatic logic [15:0] ques_of(input inst_cond_t c);
    ques_of = '0;
    ques_of[QUES_FREQ_BIT] = c.overrun;
    ques_of[QUES_AMPL_BIT] = c.over_range;
  endfunction
  // Bit 6 is left clear while masking, so it cannot feed itself.
  function automatic logic [15:0] stb_exp();
    logic [7:0] b;
    b = '0;
    b[STB_EAV_BIT] = error_queue_nonempty;
    b[STB_QSB_BIT] = |(ques_ev & ques_ena);
    b[STB_MAV_BIT] = output_pending;
    b[STB_ESB_BIT] = |(esr & ese);
    b[STB_OSB_BIT] = |(oper_ev & oper_ena);
    b[STB_RQS_BIT] = |(b & sre[7:0]);
    return {8'h00, b};
  endfunction
  task automatic close_out();
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic cmd(input cmd_t c, input logic [15:0] d);
    logic ok;
    host_u.send(c, d, ok);
    if (!ok) begin
      mismatches++;
      close_out();
    end
  endtask
  task automatic q(input cmd_t c, input logic [15:0] exp);
    int r0, n;
    r0 = host_u.rcnt;
    cmd(c, 16'h0000);
    n = 0;
    while (host_u.rcnt == r0 && n < 20) begin
      tick(1);
      n++;
    end
    if (host_u.rcnt == r0) begin
      mismatches++;
      close_out();
    end
    check(c.name(), host_u.last, exp);
  endtask
  task automatic set_cond(input inst_cond_t c);
    oper_ev |= oper_of(c) & ~oper_of(inst_cond);
    ques_ev |= ques_of(c) & ~ques_of(inst_cond);
    @(posedge core_clk);
    inst_cond <= c;
    tick(2);
  endtask
  task automatic pulse_err(input err_evt_t e);
    esr |= {e.cmd_err, e.exec_err, e.dev_err, e.query_err, 2'b00};
    @(posedge core_clk);
    err_evt <= e;
    @(posedge core_clk);
    err_evt <= '0;
    tick(1);
  endtask
  task automatic ctl(input ctl_t c);
    @(posedge core_clk);
    ctl_code <= c;
    ctl_valid <= 1'b1;
    @(posedge core_clk);
    ctl_valid <= 1'b0;
    tick(1);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_b, ctl_valid, exec_busy, selftest_fail, error_queue_nonempty, output_pending} = '0;
    ctl_code = CTL_NONE;
    inst_cond = '0;
    err_evt = '0;
    {esr, oper_ev, ques_ev, ese, sre, oper_ena, ques_ena} = '0;
    {mismatches, checked, srq_n, clr_n} = '0;
    void'($urandom(81));
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    tick(2);
    q(CMD_ESR_Q, 16'h0080);
    q(CMD_ESR_Q, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      pulse_err((i == 3) ? 4'hF : 4'($urandom));
      q(CMD_ESR_Q, esr);
      esr = '0;
    end
    for (int i = 0; i < 4; i++) begin
      inst_cond_t c;
      c = (i == 2) ? 6'h3F : (i == 3) ? 6'h00 : 6'($urandom);
      set_cond(c);
      q(CMD_OPER_COND_Q, oper_of(c));
      q(CMD_QUES_COND_Q, ques_of(c));
      q(CMD_OPER_EVT_Q, oper_ev);
      q(CMD_QUES_EVT_Q, ques_ev);
      {oper_ev, ques_ev} = '0;
    end
    cmd(CMD_OPER_ENA, 16'h0010);
    oper_ena = 16'h0010;
    q(CMD_OPER_ENA_Q, oper_ena);
    set_cond(6'h08);
    q(CMD_STB_Q, stb_exp());
    cmd(CMD_SRE, 16'h0080);
    sre = 16'h0080;
    tick(3);
    check("srq", 16'(srq_n), 16'h0001);
    q(CMD_STB_Q, stb_exp());
    cmd(CMD_QUES_ENA, 16'h0200);
    ques_ena = 16'h0200;
    set_cond(6'h09);
    q(CMD_STB_Q, stb_exp());
    cmd(CMD_ESE, 16'h003C);
    ese = 16'h003C;
    pulse_err(4'h1);
    q(CMD_ESE_Q, ese);
    q(CMD_STB_Q, stb_exp());
    cmd(CMD_CLS, 16'h0000);
    {esr, oper_ev, ques_ev} = '0;
    q(CMD_ESE_Q, ese);
    q(CMD_OPER_ENA_Q, oper_ena);
    q(CMD_STB_Q, stb_exp());
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      exec_busy <= 1'b1;
      cmd(i ? CMD_WAI : CMD_OPC, 16'h0000);
      tick(4);
      check("ready", 16'(cmd_ready), 16'h0000);
      @(posedge core_clk);
      exec_busy <= 1'b0;
      q(CMD_ESR_Q, i ? 16'h0000 : 16'h0001);
    end
    @(posedge core_clk);
    exec_busy <= 1'b1;
    fork
      begin
        repeat (6) @(posedge core_clk);
        exec_busy <= 1'b0;
      end
    join_none
    q(CMD_OPC_Q, {8'h00, ASCII_ONE});
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      selftest_fail <= i[0];
      q(CMD_TST_Q, {8'h00, i ? ASCII_ONE : ASCII_ZERO});
    end
    ctl(CTL_INIT_CLEAR);
    check("clear", 16'(clr_n), 16'h0001);
    for (int i = 0; i < 3; i++) ctl(ctl_t'(int'(CTL_REN) + i));
    check("clear", 16'(clr_n), 16'h0001);
    q(CMD_ESE_Q, ese);
    @(posedge core_clk);
    error_queue_nonempty <= 1'($urandom);
    output_pending <= 1'($urandom);
    ctl(CTL_READ_STB);
    check("ctl_stb", {8'h00, ctl_stb}, stb_exp());
    cmd(CMD_RST, 16'h0000);
    {ese, sre} = '0;
    q(CMD_ESE_Q, ese);
    q(CMD_SRE_Q, sre);
    cmd(CMD_OPER_ENA, 16'hFFFF);
    q(CMD_OPER_ENA_Q, 16'h7FFF);
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    q(CMD_ESR_Q, 16'h0080);
    close_out();
  end
endmodule
bind status_reporting status_reporting_chk chk_u (.*);
